// ==== hdl/ofm_pkg.sv ====
// constants, carriers and state layout of the option field bit mapper
`default_nettype none
package ofm_pkg;
  // field widths
  localparam int OPT_W  = 16;
  localparam int BANK_W = 4;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_TRQ_MAP = 4'h0;
  localparam logic [3:0] OFS_BNK_MAP = 4'h1;
  localparam logic [3:0] OFS_CTRL    = 4'h2;
  localparam logic [3:0] OFS_STATUS  = 4'h3;

  // values after reset
  localparam logic [15:0] TRQ_MAP_RST = 16'h1f1e;
  localparam logic [15:0] BNK_MAP_RST = 16'h0000;

  // only position digits and enable bits are stored
  localparam logic [15:0] MAP_MASK = 16'h1f1f;

  // digit layout shared by both setup registers
  localparam int POS_LO_LSB = 0;
  localparam int EN_LO_BIT  = 4;
  localparam int POS_HI_LSB = 8;
  localparam int EN_HI_BIT  = 12;

  // highest legal start bit of the bank window
  localparam logic [3:0] BANK_POS_MAX = 4'hc;

  // control and status bits
  localparam int CTRL_RESTART_BIT = 0;
  localparam int ST_PENDING_BIT   = 0;
  localparam int ST_FWD_BIT       = 1;
  localparam int ST_REV_BIT       = 2;
  localparam int ST_LATCH_BIT     = 3;
  localparam int ST_BANK_LSB      = 4;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ofm_bus_type;

  // one received motion command option field
  typedef struct packed {
    logic        valid;
    logic [15:0] option;
  } ofm_cmd_type;

  // decoded internal control signals
  typedef struct packed {
    logic                fwd_ext_torque_limit_sel;
    logic                rev_ext_torque_limit_sel;
    logic [BANK_W-1:0]   gain_bank_select;
    logic                latch_inhibit;
  } ofm_ctl_type;

  // whole state of the mapper
  typedef struct packed {
    logic [15:0] trq_shadow;
    logic [15:0] bnk_shadow;
    logic [15:0] trq_act;
    logic [15:0] bnk_act;
    ofm_ctl_type ctl;
    logic        ctl_valid;
    logic [15:0] rd_data;
  } ofm_state_type;
endpackage
`default_nettype wire

// ==== hdl/ofm_mapper.sv ====
// option field bit mapper: setup registers and command decode
// What this block does
// RULE1 - position digit k selects option field bit k, k from 0 to 15
// RULE2 - reverse torque limit select comes from the bit its digit names
// RULE3 - reverse torque limit select follows the field only when enabled
// RULE4 - bank select is four consecutive bits starting at its digit
// RULE5 - bank start digit is held to 0..C so the window fits
// RULE6 - bank select is taken from the field only when enabled
// RULE7 - forward and latch use digit plus enable; changes wait for restart
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
module ofm_mapper
  import ofm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register port
  input  wire ofm_bus_type bus,
  output var  logic [15:0] rd_data,
  // command option field
  input  wire ofm_cmd_type cmd,
  // decoded controls
  output var  ofm_ctl_type ctl,
  output var  logic        ctl_valid
);

  ofm_state_type s_reg;
  ofm_state_type s_next;

  logic restart_req;
  logic [15:0] status_word;

  // stored value of a setup write; bank digit saturates
  // saturating rather than refusing keeps a bad bank write inside the field
  function automatic logic [15:0] filt(
    input logic [15:0] v,
    input logic        is_bank
  );
    logic [15:0] r;
    r = v & MAP_MASK;
    if (is_bank && (r[3:0] > BANK_POS_MAX)) begin
      r[3:0] = BANK_POS_MAX; // see RULE5
    end
    return r;
  endfunction

  // one option bit picked by a 4-bit digit
  function automatic logic pick(
    input logic [15:0] opt,
    input logic [3:0]  pos
  );
    return opt[pos]; // see RULE1
  endfunction

  // four bits starting at a digit
  function automatic logic [3:0] window(
    input logic [15:0] opt,
    input logic [3:0]  pos
  );
    logic [15:0] sh;
    sh = opt >> pos;
    return sh[3:0]; // see RULE4
  endfunction

  // restart strobe from the control register
  assign restart_req = bus.wr && (bus.addr == OFS_CTRL)
                       && bus.wdata[CTRL_RESTART_BIT];

  // status shows pending settings and live controls
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_PENDING_BIT] = (s_reg.trq_shadow != s_reg.trq_act)
                               || (s_reg.bnk_shadow != s_reg.bnk_act);
    status_word[ST_FWD_BIT]   = s_reg.ctl.fwd_ext_torque_limit_sel;
    status_word[ST_REV_BIT]   = s_reg.ctl.rev_ext_torque_limit_sel;
    status_word[ST_LATCH_BIT] = s_reg.ctl.latch_inhibit;
    status_word[ST_BANK_LSB +: BANK_W] = s_reg.ctl.gain_bank_select;
  end

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.ctl_valid = 1'b0;
    s_next.rd_data = 16'h0000;
    // setup writes land in shadows only; decode keeps the old map
    if (bus.wr && (bus.addr == OFS_TRQ_MAP)) begin
      s_next.trq_shadow = filt(bus.wdata, 1'b0); // see RULE7
    end
    if (bus.wr && (bus.addr == OFS_BNK_MAP)) begin
      s_next.bnk_shadow = filt(bus.wdata, 1'b1); // see RULE5
    end
    // reads answer one cycle later; unmapped reads give zero
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_TRQ_MAP: s_next.rd_data = s_reg.trq_shadow;
        OFS_BNK_MAP: s_next.rd_data = s_reg.bnk_shadow;
        OFS_STATUS:  s_next.rd_data = status_word;
        default:     s_next.rd_data = 16'h0000;
      endcase
    end
    if (restart_req) begin
      // restart wins over a command in the same cycle
      s_next.trq_act = s_reg.trq_shadow; // see RULE7
      s_next.bnk_act = s_reg.bnk_shadow; // see RULE7
      s_next.ctl = '0;
    end else if (cmd.valid) begin
      s_next.ctl_valid = 1'b1;
      // forward select, digit plus enable
      if (s_reg.trq_act[EN_LO_BIT]) begin
        s_next.ctl.fwd_ext_torque_limit_sel =
          pick(cmd.option, s_reg.trq_act[POS_LO_LSB +: 4]); // see RULE7
      end else begin
        s_next.ctl.fwd_ext_torque_limit_sel = 1'b0;
      end
      // reverse select, low when disabled
      if (s_reg.trq_act[EN_HI_BIT]) begin
        s_next.ctl.rev_ext_torque_limit_sel =
          pick(cmd.option, s_reg.trq_act[POS_HI_LSB +: 4]); // see RULE2
      end else begin
        s_next.ctl.rev_ext_torque_limit_sel = 1'b0; // see RULE3
      end
      // bank select keeps its value when disabled
      if (s_reg.bnk_act[EN_LO_BIT]) begin
        s_next.ctl.gain_bank_select =
          window(cmd.option, s_reg.bnk_act[POS_LO_LSB +: 4]); // see RULE6
      end
      // latch inhibit, digit plus enable
      if (s_reg.bnk_act[EN_HI_BIT]) begin
        s_next.ctl.latch_inhibit =
          pick(cmd.option, s_reg.bnk_act[POS_HI_LSB +: 4]); // see RULE7
      end else begin
        s_next.ctl.latch_inhibit = 1'b0;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg.trq_shadow <= TRQ_MAP_RST;
      s_reg.bnk_shadow <= BNK_MAP_RST;
      s_reg.trq_act    <= TRQ_MAP_RST;
      s_reg.bnk_act    <= BNK_MAP_RST;
      s_reg.ctl        <= '0;
      s_reg.ctl_valid  <= 1'b0;
      s_reg.rd_data    <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  assign rd_data   = s_reg.rd_data;
  assign ctl       = s_reg.ctl;
  assign ctl_valid = s_reg.ctl_valid;

  // checks
  logic cmd_taken;
  assign cmd_taken = cmd.valid && !restart_req;

  chk_digit_selects_bit: assert property ( // see RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && s_reg.trq_act[EN_LO_BIT]
    |=> ctl.fwd_ext_torque_limit_sel
        == $past(cmd.option[s_reg.trq_act[3:0]]))
  else $error("forward select does not follow its bit");

  chk_rev_bit_pick: assert property ( // see RULE2
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && s_reg.trq_act[EN_HI_BIT]
    |=> ctl.rev_ext_torque_limit_sel
        == $past(cmd.option[s_reg.trq_act[11:8]]))
  else $error("reverse select does not follow its bit");

  chk_rev_disabled_low: assert property ( // see RULE3
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && !s_reg.trq_act[EN_HI_BIT]
    |=> !ctl.rev_ext_torque_limit_sel)
  else $error("disabled reverse select is not low");

  chk_bank_window: assert property ( // see RULE4
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && s_reg.bnk_act[EN_LO_BIT]
    |=> ctl.gain_bank_select
        == 4'($past(cmd.option >> s_reg.bnk_act[3:0])))
  else $error("bank select window is wrong");

  chk_bank_pos_range: assert property ( // see RULE5
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.bnk_shadow[3:0] <= BANK_POS_MAX)
    && (s_reg.bnk_act[3:0] <= BANK_POS_MAX))
  else $error("bank start digit above its limit");

  chk_bank_hold_off: assert property ( // see RULE6
    @(posedge clk_sys) disable iff (!rst_n)
    !restart_req && !s_reg.bnk_act[EN_LO_BIT]
    |=> $stable(ctl.gain_bank_select))
  else $error("bank select moved while disabled");

  chk_restart_only: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    !restart_req |=> $stable(s_reg.trq_act) && $stable(s_reg.bnk_act))
  else $error("active map changed without restart");

  chk_restart_loads: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    restart_req |=> (s_reg.trq_act == $past(s_reg.trq_shadow))
                 && (s_reg.bnk_act == $past(s_reg.bnk_shadow))
                 && !ctl_valid)
  else $error("restart did not load the shadow settings");

  chk_latch_off_low: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && !s_reg.bnk_act[EN_HI_BIT] |=> !ctl.latch_inhibit)
  else $error("disabled latch inhibit is not low");

  // decode checks for the remaining single-bit allocations, the decode pulse and the clear on restart
  chk_fwd_off_low: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && !s_reg.trq_act[EN_LO_BIT]
    |=> !ctl.fwd_ext_torque_limit_sel)
  else $error("disabled forward select is not low");

  chk_latch_bit_pick: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && s_reg.bnk_act[EN_HI_BIT]
    |=> ctl.latch_inhibit
        == $past(cmd.option[s_reg.bnk_act[11:8]]))
  else $error("latch inhibit does not follow its bit");

  chk_cmd_answer: assert property ( // see RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken |=> ctl_valid)
  else $error("taken command gave no decode pulse");

  chk_valid_only_cmd: assert property ( // see RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    !cmd_taken |=> !ctl_valid)
  else $error("decode pulse without a command");

  chk_restart_clears: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    restart_req |=> (ctl == '0))
  else $error("restart did not clear the decoded controls");

  // setup register and read port checks
  chk_trq_write_mask: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    bus.wr && (bus.addr == OFS_TRQ_MAP)
    |=> s_reg.trq_shadow == ($past(bus.wdata) & MAP_MASK))
  else $error("torque map write stored the wrong value");

  chk_map_write_only: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    !(bus.wr && (bus.addr == OFS_TRQ_MAP))
    && !(bus.wr && (bus.addr == OFS_BNK_MAP))
    |=> $stable(s_reg.trq_shadow) && $stable(s_reg.bnk_shadow))
  else $error("setup shadow changed without a write");

  chk_bank_saturate: assert property ( // see RULE5
    @(posedge clk_sys) disable iff (!rst_n)
    bus.wr && (bus.addr == OFS_BNK_MAP) && (bus.wdata[3:0] > BANK_POS_MAX)
    |=> s_reg.bnk_shadow[3:0] == BANK_POS_MAX)
  else $error("bank start digit not held at its limit");

  chk_rd_idle_zero: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    !bus.rd |=> (rd_data == 16'h0000))
  else $error("read data stand outside the read answer");

  chk_rd_map_data: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!rst_n)
    bus.rd && (bus.addr == OFS_BNK_MAP)
    |=> rd_data == $past(s_reg.bnk_shadow))
  else $error("bank map read gave the wrong data");

  cov_bank_top: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    cmd_taken && s_reg.bnk_act[EN_LO_BIT]
    && (s_reg.bnk_act[3:0] == BANK_POS_MAX));

  cov_write_restart_cmd: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    (bus.wr && bus.addr == OFS_BNK_MAP) ##[1:4] restart_req
    ##[1:4] cmd_taken);

  cov_rev_high: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctl_valid && ctl.rev_ext_torque_limit_sel);

  // covers for the latch path and for status reads with pending settings
  cov_latch_high: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctl_valid && ctl.latch_inhibit);

  cov_status_read: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    bus.rd && (bus.addr == OFS_STATUS) && status_word[ST_PENDING_BIT]);

endmodule
`default_nettype wire

// ==== bench/ofm_cmd_src.sv ====
// motion controller model issuing one option field per command
`default_nettype none
module ofm_cmd_src
  import ofm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // request from the bench
  input  wire logic        go,
  input  wire logic [15:0] opt,
  // command toward the mapper
  output var  ofm_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle field flips every cycle so stale data cannot pass as a match
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (go) begin
      cmd <= '{valid: 1'b1, option: opt};
    end else begin
      cmd <= '{valid: 1'b0, option: ~cmd.option};
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking testbench of the option field bit mapper
`default_nettype none
module tb
  import ofm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  ofm_bus_type bus     = '0;
  logic        go      = 1'b0;
  logic [15:0] opt     = 16'h0000;
  ofm_cmd_type cmd;
  logic [15:0] rd_data;
  ofm_ctl_type ctl;
  logic        ctl_valid;
  logic [15:0] v;
  int          err_count = 0;
  int          cmp_count = 0;

  // 250 MHz system clock
  initial forever #2 clk_sys = ~clk_sys;

  ofm_cmd_src src (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .opt(opt),
                   .cmd(cmd));
  ofm_mapper dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
                  .rd_data(rd_data), .cmd(cmd), .ctl(ctl),
                  .ctl_valid(ctl_valid));

  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus <= '0;
    @(posedge clk_sys) d = rd_data;
  endtask

  // send one command, wait a bounded time for the decode, compare it
  task automatic sc(input logic [15:0] o, input logic f, input logic r,
                    input logic [3:0] b, input logic l);
    bit seen;
    seen = 1'b0;
    @(posedge clk_sys) begin
      go  <= 1'b1;
      opt <= o;
    end
    @(posedge clk_sys) go <= 1'b0;
    for (int n = 0; n < 6 && !seen; n++) begin
      @(posedge clk_sys);
      seen = (ctl_valid === 1'b1);
    end
    if (!seen) begin
      err_count++;
      give_verdict();
    end else begin
      chk(16'(ctl), {9'h000, f, r, b, l});
    end
  endtask

  task automatic restart();
    wr(OFS_CTRL, 16'h0001);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_TRQ_MAP, v);
    chk(v, 16'h1f1e);
    rd(OFS_BNK_MAP, v);
    chk(v, 16'h0000);
    rd(4'h5, v);
    chk(v, 16'h0000);
    rd(OFS_STATUS, v);
    chk(v, 16'h0000);
    sc(16'h8000, 1'b0, 1'b1, 4'h0, 1'b0);
    sc(16'h4000, 1'b1, 1'b0, 4'h0, 1'b0);
    // every position digit, bit set and then every other bit set
    for (int k = 0; k < 16; k++) begin
      wr(OFS_TRQ_MAP, 16'h1000 | 16'(k << 8));
      restart();
      sc(16'(1 << k), 1'b0, 1'b1, 4'h0, 1'b0);
      sc(~16'(1 << k), 1'b0, 1'b0, 4'h0, 1'b0);
    end
    wr(OFS_TRQ_MAP, 16'hffff);
    rd(OFS_TRQ_MAP, v);
    chk(v, 16'h1f1f);
    wr(OFS_TRQ_MAP, 16'h0f1e);
    restart();
    sc(16'hffff, 1'b1, 1'b0, 4'h0, 1'b0);
    wr(OFS_BNK_MAP, 16'h0013);
    restart();
    sc(16'h0050, 1'b0, 1'b0, 4'ha, 1'b0);
    wr(OFS_BNK_MAP, 16'h101f);
    rd(OFS_BNK_MAP, v);
    chk(v, 16'h101c);
    restart();
    sc(16'ha000, 1'b0, 1'b0, 4'ha, 1'b0);
    // shadow change must not reach decode before a restart
    wr(OFS_BNK_MAP, 16'h0000);
    sc(16'h5001, 1'b1, 1'b0, 4'h5, 1'b1);
    rd(OFS_STATUS, v);
    chk(v, 16'h005b);
    restart();
    // low bits set so an ignored enable would show in bank and latch
    sc(16'hf00f, 1'b1, 1'b0, 4'h0, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
